//--- pvo_pkg.sv
// Purpose: shared constants and types of the parallel video output block
// Assumes: pixel clock comes from an outside oscillator, 42 or 21 MHz
// Notes: blanking counts are derived from times and pixel clock rates
package pvo_pkg;

    // ************************************************************
    // pixel clock rates and line timing
    // ************************************************************
    localparam int PCLK_SGL_HZ = 42_000_000;
    localparam int PCLK_DUAL_HZ = 21_000_000;
    localparam int BLANK_SHORT_NS = 6200;
    localparam int BLANK_LONG_NS = 7400;
    localparam int PIX_FULL_LINE = 1008;
    localparam int LINES_DEFAULT = 1000;
    // least times round up to whole pixel clock cycles
    localparam int BS_SGL = (BLANK_SHORT_NS * (PCLK_SGL_HZ / 1_000_000)
        + 999) / 1000;
    localparam int BL_SGL = (BLANK_LONG_NS * (PCLK_SGL_HZ / 1_000_000)
        + 999) / 1000;
    localparam int BS_DUAL = (BLANK_SHORT_NS * (PCLK_DUAL_HZ / 1_000_000)
        + 999) / 1000;
    localparam int BL_DUAL = (BLANK_LONG_NS * (PCLK_DUAL_HZ / 1_000_000)
        + 999) / 1000;
    localparam int CNT_W = 12;

    // ************************************************************
    // output modes
    // ************************************************************
    localparam logic [1:0] MODE_S10 = 2'h0;
    localparam logic [1:0] MODE_S8 = 2'h1;
    localparam logic [1:0] MODE_D8 = 2'h2;

    // ************************************************************
    // buffer and carriers
    // ************************************************************
    localparam int FIFO_DEPTH = 32;
    localparam int LANES = 16;

    typedef struct packed {
        logic [9:0] pix_b;
        logic [9:0] pix_a;
    } pvo_cam_word_t;

    typedef struct packed {
        logic frame_active_flag;
        logic line_active_flag;
        logic [LANES-1:0] lanes;
    } pvo_vid_t;

    localparam pvo_vid_t VID_RST = '0;

endpackage

//--- pvo_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level or gray-coded word
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module pvo_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        meta_r <= d_i;
        q_o <= meta_r;
    end
endmodule

//--- pvo_fifo.sv
// Purpose: dual-clock pixel buffer with gray pointers
// Assumes: DEPTH is a power of two, at least 4
// Notes: read data come from a register, shown ahead of the pop
`timescale 1ns/1ps
module pvo_fifo #(
    parameter int W = 20,
    parameter int DEPTH = 32
) (
    input wire logic wr_clk_i,
    input wire logic wr_rst_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [W-1:0] wr_data_i,
    input wire logic rd_clk_i,
    input wire logic rd_rst_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [W-1:0] rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wb_r, wg_r, rb_r, rg_r, wg_s, rg_s;
    logic out_vld_r;

    wire [AW:0] wb_inc = wb_r + 1'b1;
    wire [AW:0] rb_inc = rb_r + 1'b1;
    wire full = (wg_r == {~rg_s[AW:AW-1], rg_s[AW-2:0]});
    wire empty = (rg_r == wg_s);
    wire wr_go = wr_valid_i & ~full;
    wire load = ~empty & (~out_vld_r | rd_ready_i);

    assign wr_ready_o = ~full;
    assign rd_valid_o = out_vld_r;

    pvo_sync #(.W(AW + 1)) u_wsync (
        .clk_i(rd_clk_i),
        .d_i(wg_r),
        .q_o(wg_s)
    );

    pvo_sync #(.W(AW + 1)) u_rsync (
        .clk_i(wr_clk_i),
        .d_i(rg_r),
        .q_o(rg_s)
    );

    always_ff @(posedge wr_clk_i) begin
        if (wr_rst_i) begin
            wb_r <= '0;
            wg_r <= '0;
        end else if (wr_go) begin
            wb_r <= wb_inc;
            wg_r <= wb_inc ^ (wb_inc >> 1);
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (wr_go) begin
            mem[wb_r[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            rb_r <= '0;
            rg_r <= '0;
            out_vld_r <= 1'b0;
        end else begin
            if (load) begin
                rb_r <= rb_inc;
                rg_r <= rb_inc ^ (rb_inc >> 1);
            end
            out_vld_r <= load | (out_vld_r & ~rd_ready_i);
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (load) begin
            rd_data_o <= mem[rb_r[AW-1:0]];
        end
    end
endmodule

//--- pvo_video_out.sv
// Purpose: frame and line sequencer of the parallel video output port
// Assumes: pix_clk_i is the 42 or 21 MHz pixel clock, free running
// Notes: camera side on mclk_i, sequencer on the pixel clock
`timescale 1ns/1ps
module pvo_video_out
    import pvo_pkg::*;
#(
    parameter int NUM_LINES = LINES_DEFAULT,
    parameter int PIX_PER_LINE = PIX_FULL_LINE
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic pix_clk_i,
    input wire logic cam_valid_i,
    output logic cam_ready_o,
    input wire pvo_cam_word_t cam_word_i,
    input wire logic frame_done_i,
    input wire logic [1:0] mode_i,
    input wire logic trig_i,
    output logic cam_trig_o,
    output logic pclk_sel_o,
    output logic pixel_strobe_o,
    output pvo_vid_t vid_o,
    output logic underrun_o
);

    // ************************************************************
    // trigger pass-through and strobe
    // ************************************************************
    assign cam_trig_o = trig_i;
    // lanes change on the rising pixel clock, so the inverted strobe
    // gives the grabber half a period of setup and hold
    assign pixel_strobe_o = ~pix_clk_i;

    // ************************************************************
    // camera side (mclk_i)
    // ************************************************************
    logic [1:0] mode_m;
    logic pclk_sel_r;
    logic req_tgl_r;

    pvo_sync #(.W(2)) u_mode_m (
        .clk_i(mclk_i),
        .d_i(mode_i),
        .q_o(mode_m)
    );

    wire sel_dual = (mode_m == MODE_D8);

    // selects the 21 MHz oscillator for dual mode, else 42 MHz
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pclk_sel_r <= 1'b0;
        end else begin
            pclk_sel_r <= sel_dual;
        end
    end
    assign pclk_sel_o = pclk_sel_r;

    // acquisition done becomes a toggle for the pixel domain
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            req_tgl_r <= 1'b0;
        end else if (frame_done_i) begin
            req_tgl_r <= ~req_tgl_r;
        end
    end

    // ************************************************************
    // buffer between the domains
    // ************************************************************
    logic rst_lk;
    logic rd_valid;
    logic rd_ready;
    pvo_cam_word_t rd_word;

    pvo_sync #(.W(1)) u_rst_lk (
        .clk_i(pix_clk_i),
        .d_i(rst_i),
        .q_o(rst_lk)
    );

    pvo_fifo #(
        .W($bits(pvo_cam_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .wr_clk_i(mclk_i),
        .wr_rst_i(rst_i),
        .wr_valid_i(cam_valid_i),
        .wr_ready_o(cam_ready_o),
        .wr_data_i(cam_word_i),
        .rd_clk_i(pix_clk_i),
        .rd_rst_i(rst_lk),
        .rd_valid_o(rd_valid),
        .rd_ready_i(rd_ready),
        .rd_data_o(rd_word)
    );

    // ************************************************************
    // pixel side crossings
    // ************************************************************
    logic [1:0] mode_lk;
    logic tgl_s;
    logic tgl_d_r;
    logic pend_r;

    pvo_sync #(.W(2)) u_mode_lk (
        .clk_i(pix_clk_i),
        .d_i(mode_i),
        .q_o(mode_lk)
    );

    pvo_sync #(.W(1)) u_req (
        .clk_i(pix_clk_i),
        .d_i(req_tgl_r),
        .q_o(tgl_s)
    );

    wire req_pulse = tgl_s ^ tgl_d_r;

    // ************************************************************
    // sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_LINE = 3'b010,
        S_BLANK = 3'b100
    } pvo_state_t;

    localparam logic [CNT_W-1:0] LAST_LINE = CNT_W'(NUM_LINES - 1);
    localparam logic [CNT_W-1:0] CYC_SGL = CNT_W'(PIX_PER_LINE);
    localparam logic [CNT_W-1:0] CYC_DUAL = CNT_W'(PIX_PER_LINE / 2);

    function automatic logic [CNT_W-1:0] blank_of(
        input logic [1:0] md,
        input logic lng
    );
        logic [CNT_W-1:0] b;
        if (md == MODE_D8) begin
            b = lng ? CNT_W'(BL_DUAL) : CNT_W'(BS_DUAL);
        end else begin
            b = lng ? CNT_W'(BL_SGL) : CNT_W'(BS_SGL);
        end
        return b;
    endfunction

    pvo_state_t st_r, st_nxt;
    logic [CNT_W-1:0] pix_r, pix_nxt;
    logic [CNT_W-1:0] line_r, line_nxt;
    logic [CNT_W-1:0] blk_r, blk_nxt;
    logic long_r, long_nxt;
    logic [1:0] mode_r, mode_nxt;
    pvo_vid_t vid_r;
    logic undr_r;

    wire [CNT_W-1:0] line_cyc =
        (mode_r == MODE_D8) ? CYC_DUAL : CYC_SGL;
    wire [CNT_W-1:0] blank_len = blank_of(mode_r, long_r);
    wire start_ok = pend_r & rd_valid;
    wire pix_last = (pix_r == line_cyc - 1'b1);
    wire line_last = (line_r == LAST_LINE);
    wire blk_last = (blk_r == blank_len - 1'b1);

    always_comb begin
        st_nxt = st_r;
        pix_nxt = pix_r;
        line_nxt = line_r;
        blk_nxt = blk_r;
        long_nxt = long_r;
        mode_nxt = mode_r;
        unique case (st_r)
            S_IDLE: begin
                if (start_ok) begin
                    st_nxt = S_LINE;
                    pix_nxt = '0;
                    line_nxt = '0;
                    long_nxt = 1'b0;
                    mode_nxt = mode_lk;
                end
            end
            S_LINE: begin
                if (pix_last) begin
                    if (line_last) begin
                        st_nxt = S_IDLE;
                    end else begin
                        st_nxt = S_BLANK;
                        blk_nxt = '0;
                        line_nxt = line_r + 1'b1;
                    end
                end else begin
                    pix_nxt = pix_r + 1'b1;
                end
            end
            S_BLANK: begin
                if (blk_last) begin
                    st_nxt = S_LINE;
                    pix_nxt = '0;
                    long_nxt = ~long_r;
                end else begin
                    blk_nxt = blk_r + 1'b1;
                end
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    // ************************************************************
    // lane mapping and outputs
    // ************************************************************
    wire line_active_flag_nxt = (st_nxt == S_LINE);
    wire frame_active_flag_nxt = (st_nxt != S_IDLE);
    wire [LANES-1:0] lanes_s10 = {6'h00, rd_word.pix_a};
    wire [LANES-1:0] lanes_s8 = {8'h00, rd_word.pix_a[9:2]};
    wire [LANES-1:0] lanes_d8 =
        {rd_word.pix_b[9:2], rd_word.pix_a[9:2]};
    // an unsupported code falls back to ten-bit lanes
    wire [LANES-1:0] lanes_sel =
        (mode_nxt == MODE_D8) ? lanes_d8 :
        (mode_nxt == MODE_S8) ? lanes_s8 : lanes_s10;
    wire [LANES-1:0] lanes_nxt =
        (line_active_flag_nxt & rd_valid) ? lanes_sel : 16'h0000;

    assign rd_ready = line_active_flag_nxt;

    pvo_vid_t vid_nxt;
    assign vid_nxt = '{frame_active_flag: frame_active_flag_nxt, line_active_flag: line_active_flag_nxt, lanes: lanes_nxt};

    always_ff @(posedge pix_clk_i) begin
        if (rst_lk) begin
            st_r <= S_IDLE;
            pix_r <= '0;
            line_r <= '0;
            blk_r <= '0;
            long_r <= 1'b0;
            mode_r <= MODE_S10;
            vid_r <= VID_RST;
        end else begin
            st_r <= st_nxt;
            pix_r <= pix_nxt;
            line_r <= line_nxt;
            blk_r <= blk_nxt;
            long_r <= long_nxt;
            mode_r <= mode_nxt;
            vid_r <= vid_nxt;
        end
    end

    // a request arriving in the start cycle is kept: set wins
    always_ff @(posedge pix_clk_i) begin
        if (rst_lk) begin
            tgl_d_r <= 1'b0;
            pend_r <= 1'b0;
            undr_r <= 1'b0;
        end else begin
            tgl_d_r <= tgl_s;
            pend_r <= req_pulse | (pend_r & ~(st_r == S_IDLE & start_ok));
            undr_r <= (line_active_flag_nxt & ~rd_valid) |
                (undr_r & ~(st_r == S_IDLE & start_ok));
        end
    end

    assign vid_o = vid_r;
    assign underrun_o = undr_r;

    // ************************************************************
    // checks
    // ************************************************************
    logic [CNT_W-1:0] hi_cnt_r, lo_cnt_r, per_cnt_r;
    logic lv_d_r;
    logic h_long_r;

    wire lv_rise = vid_r.line_active_flag & ~lv_d_r;
    wire [CNT_W-1:0] exp_blank = blank_of(mode_r, h_long_r);

    always_ff @(posedge pix_clk_i) begin
        if (rst_lk) begin
            hi_cnt_r <= '0;
            lo_cnt_r <= '0;
            per_cnt_r <= '0;
            lv_d_r <= 1'b0;
            h_long_r <= 1'b0;
        end else begin
            lv_d_r <= vid_r.line_active_flag;
            hi_cnt_r <= vid_r.line_active_flag ? hi_cnt_r + 1'b1 : '0;
            lo_cnt_r <= (vid_r.frame_active_flag & ~vid_r.line_active_flag) ? lo_cnt_r + 1'b1 : '0;
            per_cnt_r <= lv_rise ? CNT_W'(1) : per_cnt_r + 1'b1;
            if (~vid_r.frame_active_flag) begin
                h_long_r <= 1'b0;
            end else if (lv_rise & lo_cnt_r != '0) begin
                h_long_r <= ~h_long_r;
            end
        end
    end

    property p_flags_idle;
        @(posedge pix_clk_i) disable iff (rst_lk)
        !vid_r.frame_active_flag |-> !vid_r.line_active_flag && vid_r.lanes == 16'h0000;
    endproperty
    a_flags_idle: assert property (p_flags_idle)
        else $error("line flag or lanes active outside frame");

    property p_frame_start;
        @(posedge pix_clk_i) disable iff (rst_lk)
        $rose(vid_r.frame_active_flag) |-> vid_r.line_active_flag && $past(pend_r);
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame began without request or line");

    property p_first_pix;
        @(posedge pix_clk_i) disable iff (rst_lk)
        $rose(vid_r.line_active_flag) && mode_r == MODE_S10 |->
            vid_r.lanes == {6'h00, $past(rd_word.pix_a)};
    endproperty
    a_first_pix: assert property (p_first_pix)
        else $error("first pixel not on lanes at line start");

    property p_line_len;
        @(posedge pix_clk_i) disable iff (rst_lk)
        $fell(vid_r.line_active_flag) |-> hi_cnt_r == line_cyc;
    endproperty
    a_line_len: assert property (p_line_len)
        else $error("line length wrong");

    property p_gap;
        @(posedge pix_clk_i) disable iff (rst_lk)
        lv_rise && lo_cnt_r != '0 |-> lo_cnt_r == exp_blank;
    endproperty
    a_gap: assert property (p_gap)
        else $error("line gap not in short-long order");

    property p_period;
        @(posedge pix_clk_i) disable iff (rst_lk)
        lv_rise && lo_cnt_r != '0 |-> per_cnt_r == line_cyc + exp_blank;
    endproperty
    a_period: assert property (p_period)
        else $error("line period wrong");

    property p_frame_end;
        @(posedge pix_clk_i) disable iff (rst_lk)
        $fell(vid_r.frame_active_flag) |-> $fell(vid_r.line_active_flag) && $past(line_r) == LAST_LINE;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("frame ended at wrong line");

    property p_drop_lsb;
        @(posedge pix_clk_i) disable iff (rst_lk)
        vid_r.line_active_flag && mode_r == MODE_S8 && $past(rd_valid) |->
            vid_r.lanes == {8'h00, $past(rd_word.pix_a[9:2])};
    endproperty
    a_drop_lsb: assert property (p_drop_lsb)
        else $error("eight-bit lanes wrong");

    property p_dual_pair;
        @(posedge pix_clk_i) disable iff (rst_lk)
        vid_r.line_active_flag && mode_r == MODE_D8 && $past(rd_valid) |->
            vid_r.lanes == {$past(rd_word.pix_b[9:2]),
                $past(rd_word.pix_a[9:2])};
    endproperty
    a_dual_pair: assert property (p_dual_pair)
        else $error("dual lanes wrong");

    property p_clk_sel;
        @(posedge mclk_i) disable iff (rst_i)
        $changed(mode_m) |=> pclk_sel_o == (mode_m == MODE_D8);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("pixel clock select wrong");

    property p_trig;
        @(posedge mclk_i) disable iff (rst_i)
        cam_trig_o == trig_i;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger not passed through");

endmodule

//--- pvo_grabber_model.sv
// Purpose: frame grabber model capturing the parallel pixel stream
// Assumes: one sample per pixel clock, on the rising strobe
// Notes: the bench reads and clears the capture queues between frames
`timescale 1ns/1ps
module pvo_grabber_model
    import pvo_pkg::*;
(
    input wire logic strobe_i,
    input wire pvo_vid_t vid_i
);
    // ************************************************************
    // capture and flag bookkeeping
    // ************************************************************
    logic [15:0] cap_q[$];
    int run_q[$];
    int gap_q[$];
    int lines_q[$];
    int run_n = 0;
    int gap_n = 0;
    int line_n = 0;
    int stray_n = 0;

    // a gap still open when the frame flag drops is counted as stray
    always @(posedge strobe_i) begin
        if (!vid_i.line_active_flag && vid_i.lanes != '0) begin
            stray_n++;
        end
        if (vid_i.frame_active_flag && vid_i.line_active_flag) begin
            cap_q.push_back(vid_i.lanes);
            run_n++;
            if (gap_n != 0) begin
                gap_q.push_back(gap_n);
            end
            gap_n = 0;
        end else begin
            if (run_n != 0) begin
                run_q.push_back(run_n);
                line_n++;
            end
            run_n = 0;
            if (vid_i.frame_active_flag) begin
                gap_n++;
            end else begin
                if (vid_i.line_active_flag || gap_n != 0) begin
                    stray_n++;
                end
                if (line_n != 0) begin
                    lines_q.push_back(line_n);
                end
                line_n = 0;
                gap_n = 0;
            end
        end
    end
endmodule

//--- pvo_tb.sv
// Purpose: self-checking bench of the parallel video output sequencer
// Assumes: short frames of 3 lines of 16 pixels
// Notes: the grabber model collects the stream, the tasks judge it
`timescale 1ns/1ps
module testbench
    import pvo_pkg::*;
;
    localparam int NL = 3;
    localparam int PIX = 16;
    logic mclk_i, rst_i, pix_clk_i, cam_valid_i, frame_done_i, trig_i;
    logic [1:0] mode_i;
    pvo_cam_word_t cam_word_i;
    logic cam_ready_o, cam_trig_o, pclk_sel_o, pixel_strobe_o, underrun_o;
    pvo_vid_t vid_o;
    int miscompares = 0;
    int checks_done = 0;
    real ph = 13.1;

    always #2.5 mclk_i = ~mclk_i;
    // odd first half period keeps the pixel clock out of phase
    always begin
        #(ph);
        ph = 80.0;
        pix_clk_i = ~pix_clk_i;
    end

    pvo_video_out #(.NUM_LINES(NL), .PIX_PER_LINE(PIX)) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .pix_clk_i(pix_clk_i),
        .cam_valid_i(cam_valid_i), .cam_ready_o(cam_ready_o),
        .cam_word_i(cam_word_i), .frame_done_i(frame_done_i),
        .mode_i(mode_i), .trig_i(trig_i), .cam_trig_o(cam_trig_o),
        .pclk_sel_o(pclk_sel_o), .pixel_strobe_o(pixel_strobe_o),
        .vid_o(vid_o), .underrun_o(underrun_o));

    pvo_grabber_model gm (.strobe_i(pixel_strobe_o), .vid_i(vid_o));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic stop_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic time_out(string what);
        miscompares++;
        $display("ERROR %s expected done seen timeout", what);
        stop_test();
    endtask

    // valid stays up across words; ready seen at a falling edge holds
    // to the next rising edge since only our writes can fill the buffer
    task automatic feed(input int nw);
        int k;
        int n;
        for (k = 0; k < nw; k++) begin
            cam_valid_i <= 1'b1;
            cam_word_i <= '{pix_b: 10'(k * 53 + 9), pix_a: 10'(k * 37 + 5)};
            @(negedge mclk_i);
            for (n = 0; n < 40000 && cam_ready_o !== 1'b1; n++) begin
                @(negedge mclk_i);
            end
            if (cam_ready_o !== 1'b1) begin
                time_out("cam_ready_o");
            end
            @(posedge mclk_i);
        end
        cam_valid_i <= 1'b0;
    endtask

    task automatic chk_trig();
        @(posedge mclk_i);
        trig_i <= 1'b1;
        @(negedge mclk_i);
        chk("cam_trig_o", 32'h1, cam_trig_o);
        @(posedge mclk_i);
        trig_i <= 1'b0;
        @(negedge mclk_i);
        chk("cam_trig_o", 32'h0, cam_trig_o);
    endtask

    // ************************************************************
    // one frame in the given mode with nw camera words
    // ************************************************************
    task automatic run_frame(input logic [1:0] md, input int nw);
        int ln;
        int i;
        int n;
        logic [9:0] a;
        logic [9:0] b;
        logic [15:0] e;
        ln = (md == MODE_D8) ? PIX / 2 : PIX;
        gm.cap_q.delete();
        gm.run_q.delete();
        gm.gap_q.delete();
        gm.lines_q.delete();
        gm.stray_n = 0;
        mode_i <= md;
        repeat (4) @(posedge pix_clk_i);
        @(posedge mclk_i);
        fork
            feed(nw);
            begin
                if (nw >= FIFO_DEPTH) begin
                    for (n = 0; n < 400 && cam_ready_o !== 1'b0; n++) begin
                        @(negedge mclk_i);
                    end
                    chk("cam_ready_o full", 32'h0, cam_ready_o);
                    chk("early pixels", 32'h0, gm.cap_q.size());
                end
                @(posedge mclk_i);
                frame_done_i <= 1'b1;
                @(posedge mclk_i);
                frame_done_i <= 1'b0;
            end
        join
        for (n = 0; n < 40000 && gm.lines_q.size() == 0; n++) begin
            @(posedge mclk_i);
        end
        if (gm.lines_q.size() == 0) begin
            time_out("frame end");
        end
        chk("lines", NL, gm.lines_q[0]);
        chk("pixels", NL * ln, gm.cap_q.size());
        chk("gaps", NL - 1, gm.gap_q.size());
        for (i = 0; i < gm.run_q.size(); i++) begin
            chk("line length", ln, gm.run_q[i]);
        end
        for (i = 0; i < gm.gap_q.size(); i++) begin
            if (md == MODE_D8) begin
                n = (i % 2 == 0) ? BS_DUAL : BL_DUAL;
            end else begin
                n = (i % 2 == 0) ? BS_SGL : BL_SGL;
            end
            chk("line gap", n, gm.gap_q[i]);
        end
        for (i = 0; i < gm.cap_q.size(); i++) begin
            a = 10'(i * 37 + 5);
            b = 10'(i * 53 + 9);
            case (md)
                MODE_S8: e = {8'h00, a[9:2]};
                MODE_D8: e = {b[9:2], a[9:2]};
                default: e = {6'h00, a};
            endcase
            if (i >= nw) begin
                e = 16'h0000;
            end
            chk("lanes", e, gm.cap_q[i]);
        end
        chk("stray flags", 32'h0, gm.stray_n);
        chk("underrun_o", 32'(nw < NL * ln), underrun_o);
        chk("pclk_sel_o", 32'(md == MODE_D8), pclk_sel_o);
        chk("vid_o idle", 32'(VID_RST), 32'(vid_o));
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        mclk_i = 1'b0;
        pix_clk_i = 1'b0;
        rst_i = 1'b1;
        cam_valid_i = 1'b0;
        cam_word_i = '0;
        frame_done_i = 1'b0;
        mode_i = MODE_S10;
        trig_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        repeat (4) @(posedge pix_clk_i);
        @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk("vid_o reset", 32'(VID_RST), 32'(vid_o));
        chk_trig();
        run_frame(MODE_S10, NL * PIX);
        run_frame(MODE_S8, NL * PIX);
        run_frame(MODE_D8, NL * PIX / 2);
        run_frame(MODE_D8, 2);
        run_frame(2'h3, NL * PIX);
        stop_test();
    end
endmodule
